// ### rtl/dsc_pkg.sv
// package of constants for the device status and checksum register bank
package dsc_pkg;
    // ==========================================================
    // register map
    localparam logic [7:0] DSC_PAGE_SELECT_OFFSET    = 8'h00;
    localparam logic [7:0] DSC_STATUS_PAGE           = 8'h00;
    localparam logic [7:0] DSC_STATUS_ONE_OFFSET     = 8'h77;
    localparam logic [7:0] DSC_CHECKSUM_OFFSET       = 8'h7e;
    // ==========================================================
    // reset values
    localparam logic [7:0] DSC_STATUS_ONE_RESET      = 8'h80;
    localparam logic [7:0] DSC_CHECKSUM_RESET        = 8'h00;
    localparam logic [7:0] DSC_PAGE_RESET            = 8'h00;
    // ==========================================================
    // field positions of the status register
    localparam int DSC_MODE_MSB                      = 7;
    localparam int DSC_MODE_LSB                      = 5;
    localparam int DSC_BOOST_BIT                     = 4;
    localparam int DSC_BIAS_BIT                      = 3;
    localparam int DSC_INPUT_FAULT_BIT               = 2;
    localparam int DSC_BIAS_FAULT_BIT                = 1;
    localparam int DSC_RECOVERY_BIT                  = 0;
    // ==========================================================
    // operating mode codes
    localparam logic [2:0] DSC_MODE_SLEEP            = 3'h4;
    localparam logic [2:0] DSC_MODE_ACTIVE_IDLE      = 3'h6;
    localparam logic [2:0] DSC_MODE_ACTIVE_ON        = 3'h7;
    // ==========================================================
    // checksum function constants
    localparam logic [7:0] DSC_CRC_POLY              = 8'h07;
    // ==========================================================
    // misc
    localparam int DSC_CHANNELS                      = 8;
endpackage : dsc_pkg

// ### rtl/dsc_checksum_step.sv
// combinational checksum step: crc-8 of one byte into the running sum
`timescale 1ns/100ps
`default_nettype none
module dsc_checksum_step
    import dsc_pkg::*;
(
    input  wire logic [7:0] current_sum,
    input  wire logic [7:0] data_byte,
    output logic      [7:0] next_sum
);
    // ==========================================================
    // bitwise crc-8, msb first
    logic [7:0] stage [0:8];
    assign stage[0] = current_sum ^ data_byte;
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_bit
            assign stage[gi+1] = stage[gi][7] ? ((stage[gi] << 1) ^ DSC_CRC_POLY) : (stage[gi] << 1);
        end
    endgenerate
    assign next_sum = stage[8];
endmodule // dsc_checksum_step
`default_nettype wire

// ### rtl/dsc_mode_decode.sv
// decodes internal power state into the operating mode code
`timescale 1ns/100ps
`default_nettype none
module dsc_mode_decode
    import dsc_pkg::*;
(
    input  wire logic                    device_active,
    input  wire logic [DSC_CHANNELS-1:0] channel_on,
    output logic      [2:0]              mode_code
);
    // ==========================================================
    // mode selection
    always_comb begin
        if (!device_active) begin
            mode_code = DSC_MODE_SLEEP;
        end else if (|channel_on) begin
            mode_code = DSC_MODE_ACTIVE_ON;
        end else begin
            mode_code = DSC_MODE_ACTIVE_IDLE;
        end
    end
endmodule // dsc_mode_decode
`default_nettype wire

// ### rtl/dsc_status_bank.sv
// device status and control-bus write checksum register bank
// Functional notes
// - mode field bits 7-5: 4 sleep, 6 active all off, 7 active some on.
// - status register reads 0x80 after reset.
// - bit 4 shows boost converter powered state.
// - bit 3 shows microphone bias supply powered state.
// - bit 2 set while any channel is down by input fault.
// - bit 1 set while all channels are down by bias fault.
// - bit 0 self-clearing recovery trigger; writing zero does nothing.
// - trigger one makes faults re-evaluated and clean supplies repowered.
// - checksum register readable; a write loads the written value.
// - checksum updates on every write to any other register, any page.
// - page select at offset 0 of each page chooses page 0 to 255.
`timescale 1ns/100ps
`default_nettype none
module dsc_status_bank
    import dsc_pkg::*;
(
    input  wire logic                    clock,
    input  wire logic                    rstn,
    input  wire logic                    clock_enable,
    // register access port from the control-bus front end
    input  wire logic                    reg_write,
    input  wire logic                    reg_read,
    input  wire logic [7:0]              reg_address,
    input  wire logic [7:0]              reg_write_data,
    output logic      [7:0]              reg_read_data,
    output logic                         reg_read_valid,
    output logic      [7:0]              current_page,
    // asynchronous power and fault state from analog section
    input  wire logic                    device_active_pin,
    input  wire logic [DSC_CHANNELS-1:0] channel_on_pin,
    input  wire logic                    boost_powered_pin,
    input  wire logic                    bias_powered_pin,
    input  wire logic                    input_fault_down_pin,
    input  wire logic                    bias_fault_down_pin,
    input  wire logic                    recovery_done_pin,
    // recovery request toward fault logic
    output logic                         recovery_request
);
    // ==========================================================
    // reset synchroniser
    logic rst_meta_n;
    logic rst_sync_n;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rst_meta_n <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_sync_n <= rst_meta_n;
        end
    end

    // ==========================================================
    // input synchronisers for the analog state
    localparam int SYNC_WIDTH = DSC_CHANNELS + 6;
    logic [SYNC_WIDTH-1:0] raw_state;
    logic [SYNC_WIDTH-1:0] sync_meta;
    logic [SYNC_WIDTH-1:0] sync_state;
    assign raw_state = {recovery_done_pin, bias_fault_down_pin, input_fault_down_pin,
                        bias_powered_pin, boost_powered_pin, device_active_pin, channel_on_pin};
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            sync_meta  <= '0;
            sync_state <= '0;
        end else if (clock_enable) begin
            sync_meta  <= raw_state;
            sync_state <= sync_meta;
        end
    end
    logic [DSC_CHANNELS-1:0] channel_on;
    logic                    device_active;
    logic                    boost_powered;
    logic                    bias_powered;
    logic                    input_fault_down;
    logic                    bias_fault_down;
    logic                    recovery_done;
    assign channel_on       = sync_state[DSC_CHANNELS-1:0];
    assign device_active    = sync_state[DSC_CHANNELS];
    assign boost_powered    = sync_state[DSC_CHANNELS+1];
    assign bias_powered     = sync_state[DSC_CHANNELS+2];
    assign input_fault_down = sync_state[DSC_CHANNELS+3];
    assign bias_fault_down  = sync_state[DSC_CHANNELS+4];
    assign recovery_done    = sync_state[DSC_CHANNELS+5];

    // ==========================================================
    // address decode
    logic hit_page;
    logic hit_status;
    logic hit_checksum;
    assign hit_page     = (reg_address == DSC_PAGE_SELECT_OFFSET);
    assign hit_status   = (current_page == DSC_STATUS_PAGE) && (reg_address == DSC_STATUS_ONE_OFFSET);
    assign hit_checksum = (current_page == DSC_STATUS_PAGE) && (reg_address == DSC_CHECKSUM_OFFSET);

    // ==========================================================
    // page select
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            current_page <= DSC_PAGE_RESET;
        end else if (clock_enable && reg_write && hit_page) begin
            current_page <= reg_write_data;
        end
    end

    // ==========================================================
    // mode decode and live status bits
    logic [2:0] mode_code;
    dsc_mode_decode u_mode (
        .device_active (device_active),
        .channel_on    (channel_on),
        .mode_code     (mode_code)
    );
    logic [7:0] status_live;
    logic       recovery_trigger;
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            status_live <= DSC_STATUS_ONE_RESET;
        end else if (clock_enable) begin
            // host data never lands in the read-only bits
            status_live[DSC_MODE_MSB:DSC_MODE_LSB] <= mode_code;
            status_live[DSC_BOOST_BIT]             <= boost_powered;
            status_live[DSC_BIAS_BIT]              <= bias_powered;
            status_live[DSC_INPUT_FAULT_BIT]       <= input_fault_down;
            status_live[DSC_BIAS_FAULT_BIT]        <= bias_fault_down;
            status_live[DSC_RECOVERY_BIT]          <= 1'b0;
        end
    end

    // ==========================================================
    // manual recovery trigger
    logic next_trigger;
    always_comb begin
        next_trigger = recovery_trigger;
        if (recovery_trigger && recovery_done) begin
            next_trigger = 1'b0;
        end
        if (reg_write && hit_status && reg_write_data[DSC_RECOVERY_BIT]) begin
            next_trigger = 1'b1;
        end
    end
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            recovery_trigger <= 1'b0;
            recovery_request <= 1'b0;
        end else if (clock_enable) begin
            recovery_trigger <= next_trigger;
            recovery_request <= next_trigger;
        end
    end

    // ==========================================================
    // checksum of bus writes
    logic [7:0] checksum;
    logic [7:0] step_one;
    logic [7:0] step_two;
    dsc_checksum_step u_step_addr (
        .current_sum (checksum),
        .data_byte   (reg_address),
        .next_sum    (step_one)
    );
    dsc_checksum_step u_step_data (
        .current_sum (step_one),
        .data_byte   (reg_write_data),
        .next_sum    (step_two)
    );
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            checksum <= DSC_CHECKSUM_RESET;
        end else if (clock_enable && reg_write) begin
            if (hit_checksum) begin
                checksum <= reg_write_data;
            end else begin
                checksum <= step_two;
            end
        end
    end

    // ==========================================================
    // read data
    logic [7:0] next_read_data;
    always_comb begin
        next_read_data = 8'h00;
        if (hit_page) begin
            next_read_data = current_page;
        end else if (hit_status) begin
            next_read_data = {status_live[7:1], recovery_trigger};
        end else if (hit_checksum) begin
            next_read_data = checksum;
        end
    end
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            reg_read_data  <= 8'h00;
            reg_read_valid <= 1'b0;
        end else if (clock_enable) begin
            reg_read_valid <= reg_read;
            if (reg_read) begin
                reg_read_data <= next_read_data;
            end
        end
    end

    // ==========================================================
    // assertions
    property p_status_reset;
        @(posedge clock)
        $rose(rst_sync_n) |-> status_live == DSC_STATUS_ONE_RESET && !recovery_trigger;
    endproperty
    a_status_reset: assert property (p_status_reset) else $error("status not at reset value");

    property p_mode_follow;
        @(posedge clock) disable iff (!rst_sync_n)
        clock_enable ##1 1'b1 |-> status_live[7:5] == $past(mode_code);
    endproperty
    a_mode_follow: assert property (p_mode_follow) else $error("mode field does not follow state");

    property p_mode_code_legal;
        @(posedge clock) disable iff (!rst_sync_n)
        (!device_active |-> mode_code == DSC_MODE_SLEEP)
        and (device_active && |channel_on |-> mode_code == DSC_MODE_ACTIVE_ON)
        and (device_active && !(|channel_on) |-> mode_code == DSC_MODE_ACTIVE_IDLE);
    endproperty
    a_mode_code_legal: assert property (p_mode_code_legal) else $error("mode code wrong");

    property p_boost_track;
        @(posedge clock) disable iff (!rst_sync_n)
        clock_enable |=> status_live[4] == $past(boost_powered);
    endproperty
    a_boost_track: assert property (p_boost_track) else $error("boost flag does not track");

    property p_bias_track;
        @(posedge clock) disable iff (!rst_sync_n)
        clock_enable |=> status_live[3] == $past(bias_powered);
    endproperty
    a_bias_track: assert property (p_bias_track) else $error("bias flag does not track");

    property p_input_fault;
        @(posedge clock) disable iff (!rst_sync_n)
        clock_enable |=> status_live[2] == $past(input_fault_down);
    endproperty
    a_input_fault: assert property (p_input_fault) else $error("input fault flag wrong");

    property p_bias_fault;
        @(posedge clock) disable iff (!rst_sync_n)
        clock_enable |=> status_live[1] == $past(bias_fault_down);
    endproperty
    a_bias_fault: assert property (p_bias_fault) else $error("bias fault flag wrong");

    property p_trigger_set;
        @(posedge clock) disable iff (!rst_sync_n)
        clock_enable && reg_write && hit_status && reg_write_data[0] |=> recovery_trigger && recovery_request;
    endproperty
    a_trigger_set: assert property (p_trigger_set) else $error("recovery trigger not set");

    property p_zero_no_effect;
        @(posedge clock) disable iff (!rst_sync_n)
        !recovery_trigger && !(reg_write && hit_status && reg_write_data[0]) |=> !recovery_trigger;
    endproperty
    a_zero_no_effect: assert property (p_zero_no_effect) else $error("trigger set without write of one");

    property p_trigger_clear;
        @(posedge clock) disable iff (!rst_sync_n)
        clock_enable && recovery_trigger && recovery_done && !(reg_write && hit_status && reg_write_data[0])
        |=> !recovery_trigger && !recovery_request;
    endproperty
    a_trigger_clear: assert property (p_trigger_clear) else $error("recovery trigger did not clear");

    property p_request_hold;
        @(posedge clock) disable iff (!rst_sync_n)
        recovery_request && !recovery_done |=> recovery_request;
    endproperty
    a_request_hold: assert property (p_request_hold) else $error("recovery request dropped early");

    property p_checksum_load;
        @(posedge clock) disable iff (!rst_sync_n)
        clock_enable && reg_write && hit_checksum |=> checksum == $past(reg_write_data);
    endproperty
    a_checksum_load: assert property (p_checksum_load) else $error("checksum not loaded");

    property p_checksum_read;
        @(posedge clock) disable iff (!rst_sync_n)
        clock_enable && reg_read && hit_checksum |=> reg_read_valid && reg_read_data == $past(checksum);
    endproperty
    a_checksum_read: assert property (p_checksum_read) else $error("checksum read back wrong");

    property p_checksum_update;
        @(posedge clock) disable iff (!rst_sync_n)
        clock_enable && reg_write && !hit_checksum |=> checksum == $past(step_two);
    endproperty
    a_checksum_update: assert property (p_checksum_update) else $error("checksum not updated");

    property p_page_load;
        @(posedge clock) disable iff (!rst_sync_n)
        clock_enable && reg_write && hit_page |=> current_page == $past(reg_write_data);
    endproperty
    a_page_load: assert property (p_page_load) else $error("page select not loaded");

    property p_status_read_only;
        @(posedge clock) disable iff (!rst_sync_n)
        clock_enable && reg_write && hit_status |=> status_live[7:1] == {$past(mode_code), $past(boost_powered),
            $past(bias_powered), $past(input_fault_down), $past(bias_fault_down)};
    endproperty
    a_status_read_only: assert property (p_status_read_only) else $error("host write reached status bits");
endmodule // dsc_status_bank
`default_nettype wire

// ### dv/dsc_host_model.sv
// host controller model driving the register access port of the status bank
`timescale 1ns/100ps
`default_nettype none
module dsc_host_model
    import dsc_pkg::*;
#(
    parameter logic [7:0] FAULT_CFG_OFFSET = 8'h3a,
    parameter logic [7:0] FAULT_CFG_RESET  = 8'h00
)(
    input  wire logic       clock,
    output var  logic       reg_write,
    output var  logic       reg_read,
    output var  logic [7:0] reg_address,
    output var  logic [7:0] reg_write_data,
    input  wire logic [7:0] reg_read_data,
    input  wire logic       reg_read_valid
);
    logic [7:0] page;
    logic [7:0] exp_sum;

    initial begin
        reg_write      = 1'b0;
        reg_read       = 1'b0;
        reg_address    = 8'h00;
        reg_write_data = 8'h00;
        page           = DSC_PAGE_RESET;
        exp_sum        = DSC_CHECKSUM_RESET;
    end

    function automatic logic [7:0] crc_step(input logic [7:0] s, input logic [7:0] b);
        logic [7:0] r;
        r = s ^ b;
        for (int i = 0; i < 8; i++) begin
            r = r[7] ? ((r << 1) ^ DSC_CRC_POLY) : (r << 1);
        end
        return r;
    endfunction

    // ==========================================================
    // bus cycles
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        reg_write      = 1'b1;
        reg_address    = a;
        reg_write_data = d;
        @(negedge clock);
        reg_write      = 1'b0;
        // released lines show the inverse so stale values cannot pass
        reg_address    = ~a;
        reg_write_data = ~d;
        if (page == DSC_STATUS_PAGE && a == DSC_CHECKSUM_OFFSET) begin
            exp_sum = d;
        end else begin
            exp_sum = crc_step(crc_step(exp_sum, a), d);
        end
        if (a == DSC_PAGE_SELECT_OFFSET) begin
            page = d;
        end
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(negedge clock);
        reg_read    = 1'b1;
        reg_address = a;
        @(negedge clock);
        reg_read    = 1'b0;
        reg_address = ~a;
        v = reg_read_valid;
        d = reg_read_data;
    endtask

    // ==========================================================
    // manual recovery sequence, caller stays on page 0
    task automatic start_recovery();
        wr(FAULT_CFG_OFFSET, FAULT_CFG_RESET);
        wr(DSC_STATUS_ONE_OFFSET, 8'h01);
    endtask

    task automatic finish_recovery(input logic [7:0] setting);
        wr(FAULT_CFG_OFFSET, setting);
    endtask
endmodule // dsc_host_model
`default_nettype wire

// ### dv/dsc_status_bank_tb.sv
// testbench of the device status and checksum register bank
`timescale 1ns/100ps
`default_nettype none
module dsc_status_bank_tb
    import dsc_pkg::*;
;
    logic                    clock = 1'b0;
    logic                    rstn = 1'b0;
    logic                    reg_write, reg_read, reg_read_valid, recovery_request;
    logic [7:0]              reg_address, reg_write_data, reg_read_data, current_page, rdata;
    logic                    active = 1'b0, boost = 1'b0, bias = 1'b0, in_flt = 1'b0, b_flt = 1'b0, done = 1'b0;
    logic [DSC_CHANNELS-1:0] chan = '0;
    logic                    cke = 1'b1;
    logic                    rvalid;
    logic [2:0]              mode;
    int                      error_cnt = 0;
    int                      compares = 0;

    always #2.5 clock = ~clock;

    dsc_status_bank dut_u (.clock(clock), .rstn(rstn), .clock_enable(cke), .reg_write(reg_write),
        .reg_read(reg_read), .reg_address(reg_address), .reg_write_data(reg_write_data),
        .reg_read_data(reg_read_data), .reg_read_valid(reg_read_valid), .current_page(current_page),
        .device_active_pin(active), .channel_on_pin(chan), .boost_powered_pin(boost),
        .bias_powered_pin(bias), .input_fault_down_pin(in_flt), .bias_fault_down_pin(b_flt),
        .recovery_done_pin(done), .recovery_request(recovery_request));

    dsc_host_model host_u (.clock(clock), .reg_write(reg_write), .reg_read(reg_read),
        .reg_address(reg_address), .reg_write_data(reg_write_data), .reg_read_data(reg_read_data),
        .reg_read_valid(reg_read_valid));

    // ==========================================================
    // checking helpers
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string what);
        host_u.rd(a, rdata, rvalid);
        chk({7'h00, rvalid}, 8'h01, "read valid");
        chk(rdata, exp, what);
    endtask

    task automatic results();
        if (error_cnt == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ==========================================================
    // tests
    initial begin
        repeat (16) @(negedge clock);
        rstn = 1'b1;
        repeat (4) @(negedge clock);
        rchk(DSC_STATUS_ONE_OFFSET, DSC_STATUS_ONE_RESET, "status after reset");
        rchk(DSC_CHECKSUM_OFFSET, DSC_CHECKSUM_RESET, "checksum after reset");
        host_u.wr(DSC_CHECKSUM_OFFSET, 8'h5a);
        rchk(DSC_CHECKSUM_OFFSET, 8'h5a, "checksum load");
        // a write while the clock enable is low must leave the checksum alone
        cke = 1'b0;
        host_u.wr(DSC_CHECKSUM_OFFSET, 8'h33);
        cke = 1'b1;
        rchk(DSC_CHECKSUM_OFFSET, 8'h5a, "frozen write");
        host_u.wr(DSC_CHECKSUM_OFFSET, 8'h5a);
        host_u.wr(DSC_STATUS_ONE_OFFSET, 8'hfe);
        rchk(DSC_STATUS_ONE_OFFSET, DSC_STATUS_ONE_RESET, "read-only write");
        rchk(DSC_CHECKSUM_OFFSET, host_u.exp_sum, "checksum after writes");
        rchk(8'h10, 8'h00, "unmapped read");
        for (int i = 0; i < 4; i++) begin
            @(negedge clock);
            active = (i > 0);
            chan   = (i == 2) ? 8'h01 : (i == 3) ? 8'h80 : 8'h00;
            boost  = i[0];
            bias   = i[1];
            in_flt = (i == 1) || (i == 3);
            b_flt  = (i >= 2);
            mode   = !active ? DSC_MODE_SLEEP : (chan != 0) ? DSC_MODE_ACTIVE_ON : DSC_MODE_ACTIVE_IDLE;
            repeat (5) @(negedge clock);
            rchk(DSC_STATUS_ONE_OFFSET, {mode, boost, bias, in_flt, b_flt, 1'b0}, "live status");
        end
        host_u.wr(DSC_STATUS_ONE_OFFSET, 8'h00);
        rchk(DSC_STATUS_ONE_OFFSET, 8'hfe, "write zero no effect");
        host_u.start_recovery();
        @(negedge clock);
        chk({7'h00, recovery_request}, 8'h01, "recovery request");
        rchk(DSC_STATUS_ONE_OFFSET, 8'hff, "trigger set");
        done = 1'b1;
        repeat (20) if (recovery_request !== 1'b0) @(negedge clock);
        chk({7'h00, recovery_request}, 8'h00, "recovery request clear");
        done = 1'b0;
        rchk(DSC_STATUS_ONE_OFFSET, 8'hfe, "trigger self clear");
        host_u.finish_recovery(8'h05);
        host_u.wr(DSC_PAGE_SELECT_OFFSET, 8'h01);
        chk(current_page, 8'h01, "page one");
        rchk(DSC_STATUS_ONE_OFFSET, 8'h00, "status not on page one");
        host_u.wr(8'h16, 8'h30);
        host_u.wr(DSC_PAGE_SELECT_OFFSET, 8'hff);
        chk(current_page, 8'hff, "page 255");
        host_u.wr(DSC_PAGE_SELECT_OFFSET, DSC_STATUS_PAGE);
        rchk(DSC_CHECKSUM_OFFSET, host_u.exp_sum, "checksum over pages");
        // second reset in mid-run with quiet pins
        {active, boost, bias, in_flt, b_flt, done} = 6'h00;
        chan = '0;
        rstn = 1'b0;
        repeat (3) @(negedge clock);
        rstn = 1'b1;
        repeat (4) @(negedge clock);
        rchk(DSC_STATUS_ONE_OFFSET, DSC_STATUS_ONE_RESET, "status after second reset");
        rchk(DSC_CHECKSUM_OFFSET, DSC_CHECKSUM_RESET, "checksum after second reset");
        chk(current_page, DSC_PAGE_RESET, "page after second reset");
        results();
    end

    initial begin
        repeat (5000) @(posedge clock);
        error_cnt++;
        results();
    end
endmodule // dsc_status_bank_tb
`default_nettype wire
